// ---- common/wss_consts.vh ----
// constants of the weld schedule sequencer: bus map, fields, modes, timing
// assumes inclusion by bare name from the core files
`ifndef WSS_CONSTS_VH
`define WSS_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define WSS_A_CTRL 8'h00
`define WSS_A_SEL 8'h04
`define WSS_A_SIDX 8'h08
`define WSS_A_SW0 8'h0c
`define WSS_A_SW1 8'h10
`define WSS_A_STAT 8'h14
`define WSS_A_PRESS 8'h18

// ----------------------------------------------------------------
// schedule word fields
// ----------------------------------------------------------------
`define WSS_F_SQZ 7:0
`define WSS_F_WELD 15:8
`define WSS_F_COOL 23:16
`define WSS_F_HOLD 31:24
`define WSS_F_OFF 7:0
`define WSS_F_HEAT 15:8
`define WSS_F_PULSE 23:16
`define WSS_F_VALVE 27:24
`define WSS_F_MODE 30:28
`define WSS_SW1_MASK 32'h7fffffff

// ----------------------------------------------------------------
// cycle modes and limits
// ----------------------------------------------------------------
`define WSS_M_NONREP 3'h0
`define WSS_M_REPEAT 3'h1
`define WSS_M_CHAIN 3'h2
`define WSS_M_SUCC 3'h3
`define WSS_M_WAIT 3'h4
`define WSS_NSCHED 100
`define WSS_LAST_SCHED 7'h63
`define WSS_WAIT_VAL 8'h63
`define WSS_HS_WAIT 2'h3
`define WSS_CTRL_RST 3'h0

// ----------------------------------------------------------------
// pressure scaling, microamps and psi
// ----------------------------------------------------------------
`define WSS_UA_ZERO 32'h00000fa0
`define WSS_UA_SPAN 32'h00003e80
`define WSS_PSI_FULL 32'h00000064

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WSS_CLK_HZ 10000000
`define WSS_BACKSTEP_MS 1500
`define WSS_BACKSTEP_CYC (`WSS_BACKSTEP_MS * (`WSS_CLK_HZ / 1000))

`endif

// ---- core/wss_sync.v ----
// two-stage synchroniser for a group of pin levels
// assumes each bit is an independent level or a slowly changing word
module wss_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire clk,
	input wire rstn,
	// levels
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);

reg [W-1:0] s1_q;
reg [W-1:0] s2_q;

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		s1_q <= {W{1'b0}};
		s2_q <= {W{1'b0}};
	end else begin
		s1_q <= din;
		s2_q <= s1_q;
	end
end

assign dout = s2_q;

endmodule // wss_sync

// ---- core/wss_backstep.v ----
// back-step switch classifier: momentary closure versus maintained closure
// assumes a synchronised, active-high switch level
module wss_backstep #(
	parameter CW = 24,
	parameter [CW-1:0] LONG_CYC = 24'd15000000
) (
	// clock and reset
	input wire clk,
	input wire rstn,
	// switch level and events
	input wire level,
	output reg short_p,
	output reg long_p
);

reg [CW-1:0] cnt_q;
reg fired_q;
reg held_q;

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		cnt_q <= {CW{1'b0}};
		fired_q <= 1'b0;
		held_q <= 1'b0;
		short_p <= 1'b0;
		long_p <= 1'b0;
	end else begin
		held_q <= level;
		short_p <= 1'b0;
		long_p <= 1'b0;
		if (level) begin
			if (!fired_q) begin
				if (cnt_q == LONG_CYC - 1'b1) begin
					fired_q <= 1'b1;
					long_p <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end else begin
			// release before the long time counts as one step back
			if (held_q && !fired_q)
				short_p <= 1'b1;
			cnt_q <= {CW{1'b0}};
			fired_q <= 1'b0;
		end
	end
end

endmodule // wss_backstep

// ---- core/wss_sequencer.v ----
// weld schedule sequencer: schedule store, interval engine, cycle modes
// assumes AHB-Lite single word transfers, a line-cycle pulse pin and
// switch pins that read 1 while closed
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`include "wss_consts.vh"

// Functional notes
// R1: store 100 schedules, each with own cycle mode, any launchable.
// R2: valve of active schedule switches on at start of squeeze.
// R3: squeeze counts out but weld waits for pressure switch closed.
// R4: weld current at programmed heat for exactly programmed weld time.
// R5: pulsation alternates weld and cool until pulse count used, then hold.
// R6: hold keeps current off, valve on; non-repeat ends valve at hold end.
// R7: repeat: initiation still closed after off restarts at squeeze.
// R8: repeat decided by each schedule's own mode, never inherited.
// R9: chained: schedule N ends, N+1 starts with its own parameters.
// R10: chained last schedule reruns whole chain while initiation held.
// R11: in chain, non-repeat ends; repeat restarts at initiated schedule.
// R12: successive in chain ends, display last plus one, waits initiation.
// R13: wait-here pauses at interval set to 99 until new initiation.
// R14: zero hold, off, squeeze between chained welds keeps current on.
// R15: after chain, display from external select or last entered number.
// R16: successive runs one schedule, increments display, returns ready.
// R17: external successive series returns to selected schedule at end.
// R18: momentary back-step moves pending schedule back one, down to first.
// R19: back-step held about 1.5 s returns pending to series first.
// R20: pressure scaled linearly, 4.00 mA zero, 20.00 mA at 100 PSI.
// R21: wait-here mode accepted only when handshake level is 3.
// R22: wait-here keeps valves and weld; aborts on e-stop or temp open.
// R23: intervals count whole line cycles; zero skips the interval.
module wss_sequencer #(
	parameter NSCHED = `WSS_NSCHED,
	parameter [23:0] BACKSTEP_CYC = `WSS_BACKSTEP_CYC
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// switch and sensor pins
	input wire line_sync,
	input wire initiate,
	input wire pressure_ok,
	input wire estop_ok,
	input wire temp_ok,
	input wire back_step_input,
	input wire [6:0] external_schedule_select_inputs,
	input wire [15:0] press_fb_ua,
	// actuator and display outputs
	output reg [3:0] valve_out,
	output reg weld_on,
	output reg [7:0] heat_out,
	output reg [6:0] disp_sched,
	output reg seq_busy,
	output reg [15:0] press_cmd_ua
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam S_IDLE = 3'h0;
localparam S_SQZ = 3'h1;
localparam S_WELD = 3'h2;
localparam S_COOL = 3'h3;
localparam S_HOLD = 3'h4;
localparam S_OFF = 3'h5;

// ----------------------------------------------------------------
// functions
// ----------------------------------------------------------------
function [6:0] clamp_sched;
	input [6:0] v;
	begin
		clamp_sched = (v > `WSS_LAST_SCHED) ? `WSS_LAST_SCHED : v;
	end
endfunction

function [15:0] psi_to_ua;
	input [6:0] psi;
	reg [31:0] t;
	begin
		t = `WSS_UA_ZERO + ({25'h0, psi} * `WSS_UA_SPAN) / `WSS_PSI_FULL;
		psi_to_ua = t[15:0];
	end
endfunction

function [6:0] ua_to_psi;
	input [15:0] ua;
	reg [31:0] t;
	begin
		if ({16'h0, ua} <= `WSS_UA_ZERO)
			t = 32'h0;
		else
			t = (({16'h0, ua} - `WSS_UA_ZERO) * `WSS_PSI_FULL) / `WSS_UA_SPAN;
		if (t > `WSS_PSI_FULL)
			t = `WSS_PSI_FULL;
		ua_to_psi = t[6:0];
	end
endfunction

// ----------------------------------------------------------------
// pin synchronisers and back-step
// ----------------------------------------------------------------
wire [28:0] pins_s;
wire line_s;
wire ini_s;
wire pr_s;
wire estop_s;
wire temp_s;
wire bstep_s;
wire [6:0] ext_s;
wire [15:0] fb_s;
wire bs_short;
wire bs_long;

wss_sync #(.W(29)) u_sync (
	.clk(hclk),
	.rstn(hresetn),
	.din({line_sync, initiate, pressure_ok, estop_ok, temp_ok,
		back_step_input, external_schedule_select_inputs, press_fb_ua}),
	.dout(pins_s)
);

assign {line_s, ini_s, pr_s, estop_s, temp_s, bstep_s, ext_s, fb_s} = pins_s;

wss_backstep #(.CW(24), .LONG_CYC(BACKSTEP_CYC)) u_bstep (
	.clk(hclk),
	.rstn(hresetn),
	.level(bstep_s),
	.short_p(bs_short),
	.long_p(bs_long)
);

reg line_d_q;
reg ini_d_q;
wire tick = line_s & ~line_d_q;
wire ini_rise = ini_s & ~ini_d_q;
wire safe = estop_s & temp_s;

// ----------------------------------------------------------------
// register file and schedule store
// ----------------------------------------------------------------
reg [31:0] sw0_mem [0:NSCHED-1];
reg [31:0] sw1_mem [0:NSCHED-1];
reg ext_mode_q;
reg [1:0] hs_level_q;
reg [6:0] sel_int_q;
reg [6:0] sidx_q;
reg [6:0] psi_q;
reg [7:0] a_q;
reg wv_q;
reg rd1_q;
reg [31:0] rmux;
reg [2:0] state_q;
reg [6:0] cur_q;
reg [6:0] disp_q;
reg succ_pend_q;
integer i;

wire acc = hsel & htrans[1] & hready;
wire [31:0] wmode = {1'b0, hwdata[30:0]};
// a write that asks for wait-here keeps the old mode below level 3
wire wait_ok = (hwdata[`WSS_F_MODE] != `WSS_M_WAIT) ||
	(hs_level_q == `WSS_HS_WAIT);

assign hreadyout = ~rd1_q;
assign hresp = 1'b0;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		a_q <= 8'h00;
		wv_q <= 1'b0;
		rd1_q <= 1'b0;
		ext_mode_q <= 1'b0;
		hs_level_q <= 2'h0;
		sel_int_q <= 7'h00;
		sidx_q <= 7'h00;
		psi_q <= 7'h00;
		hrdata <= 32'h0;
		for (i = 0; i < NSCHED; i = i + 1) begin
			sw0_mem[i] <= 32'h0;
			sw1_mem[i] <= 32'h0;
		end
	end else begin
		wv_q <= acc & hwrite;
		rd1_q <= acc & ~hwrite;
		if (acc)
			a_q <= haddr[7:0];
		// reads take one wait cycle so a preceding write is seen
		if (rd1_q)
			hrdata <= rmux;
		if (wv_q) begin
			case (a_q)
			`WSS_A_CTRL: begin
				ext_mode_q <= hwdata[0];
				hs_level_q <= hwdata[2:1];
			end
			`WSS_A_SEL: sel_int_q <= clamp_sched(hwdata[6:0]);
			`WSS_A_SIDX: sidx_q <= clamp_sched(hwdata[6:0]);
			`WSS_A_SW0: sw0_mem[sidx_q] <= hwdata;
			`WSS_A_SW1: begin
				if (wait_ok) // [R21]
					sw1_mem[sidx_q] <= wmode & `WSS_SW1_MASK;
				else
					sw1_mem[sidx_q] <= {1'b0,
						sw1_mem[sidx_q][`WSS_F_MODE], hwdata[27:0]};
			end
			`WSS_A_PRESS: psi_q <= (hwdata[6:0] > 7'h64) ? 7'h64 :
				hwdata[6:0];
			default: ;
			endcase
		end
	end
end

always @* begin
	case (a_q)
	`WSS_A_CTRL: rmux = {29'h0, hs_level_q, ext_mode_q};
	`WSS_A_SEL: rmux = {25'h0, sel_int_q};
	`WSS_A_SIDX: rmux = {25'h0, sidx_q};
	`WSS_A_SW0: rmux = sw0_mem[sidx_q];
	`WSS_A_SW1: rmux = sw1_mem[sidx_q];
	`WSS_A_STAT: rmux = {6'h0, weld_on, succ_pend_q, 1'b0, cur_q,
		1'b0, disp_q, 5'h0, state_q};
	`WSS_A_PRESS: rmux = {9'h0, ua_to_psi(fb_s), 9'h0, psi_q}; // [R20]
	default: rmux = 32'h0;
	endcase
end

// ----------------------------------------------------------------
// active schedule fields
// ----------------------------------------------------------------
wire [31:0] w0 = sw0_mem[cur_q]; // [R1]
wire [31:0] w1 = sw1_mem[cur_q];
wire [2:0] f_mode = w1[`WSS_F_MODE];
wire [6:0] sel_now = ext_mode_q ? clamp_sched(ext_s) : sel_int_q;

reg [7:0] fval;
always @* begin
	case (state_q)
	S_SQZ: fval = w0[`WSS_F_SQZ];
	S_WELD: fval = w0[`WSS_F_WELD];
	S_COOL: fval = w0[`WSS_F_COOL];
	S_HOLD: fval = w0[`WSS_F_HOLD];
	S_OFF: fval = w1[`WSS_F_OFF];
	default: fval = 8'h00;
	endcase
end

// ----------------------------------------------------------------
// interval engine
// ----------------------------------------------------------------
reg [6:0] start_q;
reg [6:0] first_q;
reg [7:0] cnt_q;
reg [7:0] pulses_q;
reg ent_q;

wire run = (state_q != S_IDLE);
wire waiting = run && (f_mode == `WSS_M_WAIT) &&
	(fval == `WSS_WAIT_VAL); // [R13]
wire expired = run && !ent_q && (cnt_q == 8'h00) && !waiting;
wire sqz_hold = (state_q == S_SQZ) && !pr_s;
wire done = expired && !sqz_hold; // [R3]
wire launch = ini_rise && safe && ((state_q == S_IDLE) || waiting);
wire [6:0] nxt_sched = (cur_q == `WSS_LAST_SCHED) ? 7'h00 :
	cur_q + 7'h01;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		line_d_q <= 1'b0;
		ini_d_q <= 1'b0;
		state_q <= S_IDLE;
		cur_q <= 7'h00;
		start_q <= 7'h00;
		first_q <= 7'h00;
		disp_q <= 7'h00;
		succ_pend_q <= 1'b0;
		cnt_q <= 8'h00;
		pulses_q <= 8'h00;
		ent_q <= 1'b0;
	end else begin
		line_d_q <= line_s;
		ini_d_q <= ini_s;
		if (run && !safe) begin
			state_q <= S_IDLE; // [R22]
		end else if (launch) begin
			// a new initiation also releases a wait-here pause
			cur_q <= disp_q;
			start_q <= disp_q; // [R11]
			if (!succ_pend_q)
				first_q <= disp_q;
			state_q <= S_SQZ; // [R2]
			ent_q <= 1'b1;
		end else if (run && ent_q) begin
			cnt_q <= fval; // [R23]
			ent_q <= 1'b0;
		end else if (run && !done) begin
			if (tick && !waiting && cnt_q != 8'h00)
				cnt_q <= cnt_q - 8'h01; // [R4] [R23]
		end else if (done) begin
			ent_q <= 1'b1;
			case (state_q)
			S_SQZ: begin
				state_q <= S_WELD;
				pulses_q <= (w1[`WSS_F_PULSE] == 8'h00) ? 8'h01 :
					w1[`WSS_F_PULSE];
			end
			S_WELD: begin
				if (pulses_q > 8'h01) begin
					pulses_q <= pulses_q - 8'h01;
					state_q <= S_COOL; // [R5]
				end else begin
					state_q <= S_HOLD; // [R5]
				end
			end
			S_COOL: state_q <= S_WELD; // [R5]
			S_HOLD: begin
				if (f_mode == `WSS_M_REPEAT || f_mode == `WSS_M_CHAIN)
					state_q <= S_OFF;
				else
					state_q <= S_IDLE; // [R6] [R11] [R16]
				if (f_mode == `WSS_M_SUCC) begin
					disp_q <= nxt_sched; // [R12] [R16]
					succ_pend_q <= 1'b1;
				end else if (f_mode != `WSS_M_REPEAT &&
					f_mode != `WSS_M_CHAIN) begin
					succ_pend_q <= 1'b0; // [R15] [R17]
				end
			end
			S_OFF: begin
				if (f_mode == `WSS_M_CHAIN &&
					cur_q != `WSS_LAST_SCHED) begin
					cur_q <= nxt_sched; // [R9] [R14]
					state_q <= S_SQZ;
				end else if (ini_s) begin
					cur_q <= start_q; // [R7] [R8] [R10] [R11]
					state_q <= S_SQZ;
				end else begin
					state_q <= S_IDLE;
					succ_pend_q <= 1'b0;
				end
			end
			default: state_q <= S_IDLE;
			endcase
		end else begin
			// idle: display follows selection unless a step is pending
			if (!succ_pend_q)
				disp_q <= sel_now; // [R15] [R17]
			else if (bs_long)
				disp_q <= first_q; // [R19]
			else if (bs_short && disp_q != first_q)
				disp_q <= disp_q - 7'h01; // [R18]
		end
	end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
// zero-length intervals between welds pass without dropping current
wire passing = (fval == 8'h00) && !sqz_hold;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		valve_out <= 4'h0;
		weld_on <= 1'b0;
		heat_out <= 8'h00;
		disp_sched <= 7'h00;
		seq_busy <= 1'b0;
		press_cmd_ua <= 16'h0fa0;
	end else begin
		seq_busy <= run;
		disp_sched <= run ? cur_q : disp_q;
		press_cmd_ua <= psi_to_ua(psi_q); // [R20]
		if (run && safe) begin
			valve_out <= w1[`WSS_F_VALVE]; // [R2] [R6] [R22]
			if (state_q == S_WELD || (weld_on && passing)) begin
				weld_on <= 1'b1; // [R4] [R14]
				heat_out <= w1[`WSS_F_HEAT];
			end else begin
				weld_on <= 1'b0; // [R6]
				heat_out <= 8'h00;
			end
		end else begin
			valve_out <= 4'h0;
			weld_on <= 1'b0;
			heat_out <= 8'h00;
		end
	end
end

endmodule // wss_sequencer

// ---- testbench/wss_sequencer_sva.sv ----
// checker on the sequencer top ports: bus timing and output safety
// assumes hready is the looped-back hreadyout
module wss_sequencer_sva (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// bus
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	// pins
	input wire pressure_ok,
	input wire estop_ok,
	input wire [3:0] valve_out,
	input wire weld_on,
	input wire seq_busy,
	input wire [15:0] press_cmd_ua
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	wire req = hsel && htrans[1] && hready;
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (req && hwrite |=> hreadyout)
		else $error("write stalled");
	a_idle_quiet: assert property (
		(!seq_busy)[*3] |-> valve_out == 4'h0 && !weld_on)
		else $error("outputs active while idle");
	a_weld_busy: assert property (
		weld_on |-> seq_busy || $past(seq_busy))
		else $error("weld current outside a sequence");
	a_estop_stop: assert property (
		$fell(estop_ok) |-> ##[1:6] (valve_out == 4'h0 && !weld_on))
		else $error("stop input did not drop outputs");
	a_press_wait: assert property (
		(!pressure_ok)[*6] |-> !$rose(weld_on))
		else $error("weld began with pressure switch open");
	a_press_span: assert property (press_cmd_ua >= 16'h0fa0 &&
		press_cmd_ua <= 16'h4e20 && (press_cmd_ua - 16'h0fa0) % 160 == 0)
		else $error("pressure command off scale");
endmodule // wss_sequencer_sva

bind wss_sequencer wss_sequencer_sva i_sva (.hclk, .hresetn, .hsel, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .pressure_ok, .estop_ok,
	.valve_out, .weld_on, .seq_busy, .press_cmd_ua);

// ---- testbench/wss_partner.sv ----
// far side model: mains tick, pressure switch and pressure sensor
// assumes valve_out and press_cmd_ua come from the sequencer
module wss_partner #(
	parameter TICK = 32
) (
	// clock
	input wire hclk,
	// from the sequencer, and dly from the bench
	input wire [3:0] valve_out,
	input wire [15:0] press_cmd_ua,
	input wire [7:0] dly,
	// to the sequencer
	output logic line_sync,
	output logic pressure_ok,
	output logic [15:0] press_fb_ua
);
	timeunit 1ns;
	timeprecision 1ns;
	int ph = 0;
	int pc = 0;
	initial begin
		line_sync = 1'b0;
		pressure_ok = 1'b0;
		press_fb_ua = 16'h0fa0;
	end
	always @(posedge hclk) begin
		ph <= (ph + 1) % TICK;
		line_sync <= (ph < TICK / 2);
		// pressure builds only dly cycles after a valve opens
		pc <= (valve_out == 4'h0) ? 0 : pc + 1;
		pressure_ok <= (valve_out != 4'h0) && (pc >= dly);
		// sensor follows the commanded current
		press_fb_ua <= press_cmd_ua;
	end
endmodule // wss_partner

// ---- testbench/wss_sequencer_tb.sv ----
// self-checking bench for the weld schedule sequencer
// assumes the partner model closes the mains, pressure and sensor loop
`include "wss_consts.vh"
module wss_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic initiate = 1'b0;
	logic estop_ok = 1'b1;
	logic back_step_input = 1'b0;
	logic temp_ok = 1'b1;
	logic ls_q = 1'b0;
	logic wo_q = 1'b0;
	logic [1:0] lp_q = 2'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] vseen = 4'h0;
	logic [6:0] ext_sel = 7'h0;
	logic [7:0] dly = 8'h02;
	logic [7:0] ha;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rng = 32'h26e9a6e0;
	logic [31:0] rd, w, v;
	logic [7:0] heats[$];
	wire hreadyout, hresp, line_sync, pressure_ok, weld_on, seq_busy;
	wire [31:0] hrdata;
	wire [15:0] press_fb_ua, press_cmd_ua;
	wire [7:0] heat_out;
	wire [3:0] valve_out;
	wire [6:0] disp_sched;
	int failures = 0;
	int cmp_count = 0;
	int wticks = 0;
	int p;
	always #50 hclk = ~hclk;

	wss_sequencer #(.BACKSTEP_CYC(24'd20)) i_dut (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .line_sync, .initiate, .pressure_ok,
		.estop_ok, .temp_ok, .back_step_input,
		.external_schedule_select_inputs(ext_sel), .press_fb_ua, .valve_out,
		.weld_on, .heat_out, .disp_sched, .seq_busy, .press_cmd_ua);
	wss_partner i_far (.hclk, .valve_out, .press_cmd_ua, .dly, .line_sync,
		.pressure_ok, .press_fb_ua);

	// ----------------------------------------------------------------
	// monitors and tasks
	// ----------------------------------------------------------------
	// line ticks reach the interval counter two clocks after the pin
	always @(posedge hclk)
		lp_q <= {lp_q[0], line_sync};
	always @(negedge hclk) begin
		if (weld_on && lp_q[1] && !ls_q)
			wticks++;
		if (weld_on && !wo_q)
			heats.push_back(heat_out);
		vseen = vseen | valve_out;
		ls_q = lp_q[1];
		wo_q = weld_on;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic summarize();
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic hr_wait();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			n++;
			@(posedge hclk);
		end
		if (n >= 50) begin
			failures++;
			summarize();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		hr_wait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hr_wait();
		rd = hrdata;
	endtask
	task automatic prog(input int s, input logic [31:0] w0,
		input logic [31:0] w1);
		bus(1'b1, `WSS_A_SIDX, s);
		bus(1'b1, `WSS_A_SW0, w0);
		bus(1'b1, `WSS_A_SW1, w1);
		bus(1'b0, `WSS_A_SW1, 0);
		chk(rd, w1 & `WSS_SW1_MASK);
	endtask
	task automatic run(input int lim, input int hold);
		int n;
		n = 0;
		wticks = 0;
		vseen = 4'h0;
		heats.delete();
		initiate <= 1'b1;
		repeat (hold) @(posedge hclk);
		initiate <= 1'b0;
		chk(seq_busy, 1);
		while (seq_busy === 1'b1 && n < lim) begin
			n++;
			@(posedge hclk);
		end
		if (n >= lim) begin
			failures++;
			summarize();
		end
		repeat (4) @(posedge hclk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 0; a < 32; a += 4) begin
			bus(1'b0, a[7:0], 0);
			chk(rd, 0);
		end
		rng = xs(rng);
		w = rng & 32'h3fffffff;
		prog(120, xs(rng), w);
		bus(1'b0, `WSS_A_SIDX, 0);
		chk(rd, 99);
		v = ((w ^ 32'h00ff0000) & 32'h0fffffff) | 32'h40000000;
		bus(1'b1, `WSS_A_SW1, v);
		bus(1'b0, `WSS_A_SW1, 0);
		chk(rd, (v & 32'h0fffffff) | (w & 32'h70000000));
		ext_sel <= 7'h70;
		bus(1'b1, `WSS_A_CTRL, 32'h7);
		repeat (6) @(posedge hclk);
		chk(disp_sched, 99);
		bus(1'b1, `WSS_A_CTRL, 32'h6);
		prog(99, 0, v);
		for (int i = 0; i < 4; i++) begin
			rng = xs(rng);
			p = (i == 0) ? 120 : rng % 101;
			bus(1'b1, `WSS_A_PRESS, p);
			repeat (8) @(posedge hclk);
			p = (p > 100) ? 100 : p;
			chk(press_cmd_ua, 4000 + p * 160);
			bus(1'b0, `WSS_A_PRESS, 0);
			chk({rd[22:16], rd[6:0]}, {p[6:0], p[6:0]});
		end
		for (int s = 0; s < 2; s++) begin
			rng = xs(rng);
			ha = rng[7:0];
			dly <= s ? 8'h3c : 8'h02;
			prog(1, 32'h02010302, {8'h05, 8'h02, ha, 8'h00});
			bus(1'b1, `WSS_A_SEL, 1);
			run(2000, 8);
			chk(wticks, 6);
			chk(vseen, 5);
			chk({16'(heats.size()), heats[0], heats[1]}, {16'd2, ha, ha});
			chk(disp_sched, 1);
		end
		dly <= 8'h02;
		prog(2, 32'h01000101, {8'h11, 8'h01, ha, 8'h02});
		bus(1'b1, `WSS_A_SEL, 2);
		run(2000, 220);
		chk(wticks, 2);
		chk(heats.size(), 2);
		prog(6, 32'h63000101, {8'h41, 8'h01, ha, 8'h00});
		bus(1'b1, `WSS_A_SEL, 6);
		for (int j = 0; j < 2; j++) begin
			heats.delete();
			initiate <= 1'b0;
			repeat (4) @(posedge hclk);
			initiate <= 1'b1;
			repeat (300) @(posedge hclk);
			chk({seq_busy, valve_out}, 5'h11);
			chk(heats.size(), 1);
		end
		temp_ok <= 1'b0;
		repeat (8) @(posedge hclk);
		chk({seq_busy, weld_on, valve_out}, 0);
		temp_ok <= 1'b1;
		initiate <= 1'b0;
		repeat (8) @(posedge hclk);
		prog(3, 32'h00000201, {8'h21, 8'h01, ha, 8'h00});
		prog(4, 32'h01000200, {8'h31, 8'h01, ~ha, 8'h00});
		bus(1'b1, `WSS_A_SEL, 3);
		run(2000, 8);
		chk(wticks, 4);
		chk({16'(heats.size()), heats[0]}, {16'd1, ha});
		chk(disp_sched, 5);
		bus(1'b0, `WSS_A_STAT, 0);
		chk(rd[24], 1);
		for (int k = 0; k < 2; k++) begin
			back_step_input <= 1'b1;
			repeat (k ? 40 : 5) @(posedge hclk);
			back_step_input <= 1'b0;
			repeat (10) @(posedge hclk);
			chk(disp_sched, k ? 3 : 4);
		end
		initiate <= 1'b1;
		repeat (12) @(posedge hclk);
		estop_ok <= 1'b0;
		repeat (8) @(posedge hclk);
		chk({seq_busy, weld_on, valve_out}, 0);
		estop_ok <= 1'b1;
		initiate <= 1'b0;
		repeat (8) @(posedge hclk);
		summarize();
	end
endmodule // wss_sequencer_tb
